/* File: design/pea_pkg.sv */
/*
 Shared constants of the parallel EEPROM host: widths, page geometry,
 strobe timing and the counts derived from them at the 250 MHz clock.
 Assumes a single clock domain; no registers reachable by software.
*/
package pea_pkg;
   localparam int CLK_MHZ = 250;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int PAGE_LSB = 8;
   localparam int PAGE_BYTES = 256;
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   // Strobe phases in ns, rounded up to whole cycles
   localparam int T_SETUP_NS = 20;
   localparam int T_WE_LOW_NS = 100;
   localparam int T_ACC_NS = 120;
   localparam int T_HOLD_NS = 20;
   localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] WE_LOW_CYC = 8'((T_WE_LOW_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS * CLK_MHZ + 999) / 1000);
   // Byte load window and worst programming time
   localparam int T_LOAD_WIN_US = 100;
   localparam int LOAD_WIN_CYC = T_LOAD_WIN_US * CLK_MHZ;
   localparam int T_PROG_MAX_US = 10000;
   localparam int PROG_MAX_CYC = T_PROG_MAX_US * CLK_MHZ;
   localparam int WIN_MARGIN_CYC = 64;
   localparam int TMR_W = 22;
endpackage : pea_pkg

/* File: design/pea_cyc_if.sv */
/*
 Link between the host sequencer and the pin strobe generator.
 Assumes both ends share ref_clk_i; start, done and we_fell are pulses.
*/
`timescale 1ns/1ps
`default_nettype none
interface pea_cyc_if;
   logic start;
   logic wr;
   logic [pea_pkg::ADDR_W-1:0] addr;
   logic [pea_pkg::DATA_W-1:0] wdata;
   logic done;
   logic we_fell;
   logic [pea_pkg::DATA_W-1:0] rdata;
   modport ctl (output start, wr, addr, wdata, input done, we_fell, rdata);
   modport cyc (input start, wr, addr, wdata, output done, we_fell, rdata);
endinterface : pea_cyc_if
`default_nettype wire

/* File: design/pea_strobe.sv */
/*
 Generates one read or write bus cycle on the memory pins.
 Assumes start comes only while idle; data_i is synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pea_strobe (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Sequencer side
   pea_cyc_if.cyc cyc,
   // Memory pins
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic [pea_pkg::ADDR_W-1:0] addr_o,
   output logic [pea_pkg::DATA_W-1:0] data_o,
   output logic data_oe_n_o,
   input wire logic [pea_pkg::DATA_W-1:0] data_i
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_SETUP = 2'b01, ST_ACT = 2'b10, ST_HOLD = 2'b11
   } pea_st_t;
   pea_st_t st_reg, st_next;
   logic [7:0] cnt_reg, cnt_next;
   logic wr_reg, wr_next;
   logic ce_n_next, oe_n_next, we_n_next, doe_n_next;
   logic [pea_pkg::ADDR_W-1:0] addr_next;
   logic [pea_pkg::DATA_W-1:0] data_next, rdata_next;
   logic done_next, fell_next;

   // Phase sequencing of the pins
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg - 8'd1;
      wr_next = wr_reg;
      ce_n_next = ce_n_o;
      oe_n_next = oe_n_o;
      we_n_next = we_n_o;
      doe_n_next = data_oe_n_o;
      addr_next = addr_o;
      data_next = data_o;
      rdata_next = cyc.rdata;
      done_next = 1'b0;
      fell_next = 1'b0;
      unique case (st_reg)
         ST_IDLE: begin
            cnt_next = cnt_reg;
            if (cyc.start) begin
               st_next = ST_SETUP;
               cnt_next = pea_pkg::SETUP_CYC - 8'd1;
               wr_next = cyc.wr;
               addr_next = cyc.addr; // [RULE1]
               data_next = cyc.wdata;
               ce_n_next = 1'b0; // [RULE2]
               doe_n_next = !cyc.wr; // [RULE5]
            end
         end
         ST_SETUP: if (cnt_reg == 8'd0) begin
            st_next = ST_ACT;
            if (wr_reg) begin
               // Address settled before the strobe falls [RULE7]
               we_n_next = 1'b0; // [RULE6]
               fell_next = 1'b1;
               cnt_next = pea_pkg::WE_LOW_CYC - 8'd1; // [RULE20]
            end else begin
               oe_n_next = 1'b0; // [RULE3]
               cnt_next = pea_pkg::ACC_CYC - 8'd1;
            end
         end
         ST_ACT: if (cnt_reg == 8'd0) begin
            st_next = ST_HOLD;
            cnt_next = pea_pkg::HOLD_CYC - 8'd1;
            we_n_next = 1'b1; // Data still driven at rise [RULE8]
            oe_n_next = 1'b1; // [RULE4]
            if (!wr_reg) rdata_next = data_i;
         end
         ST_HOLD: if (cnt_reg == 8'd0) begin
            st_next = ST_IDLE;
            ce_n_next = 1'b1;
            doe_n_next = 1'b1;
            done_next = 1'b1;
         end
      endcase
   end

   // State and pin registers
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= ST_IDLE;
         cnt_reg <= 8'h00;
         wr_reg <= 1'b0;
         ce_n_o <= 1'b1;
         oe_n_o <= 1'b1;
         we_n_o <= 1'b1;
         data_oe_n_o <= 1'b1;
         addr_o <= '0;
         data_o <= '0;
         cyc.rdata <= '0;
         cyc.done <= 1'b0;
         cyc.we_fell <= 1'b0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         wr_reg <= wr_next;
         ce_n_o <= ce_n_next;
         oe_n_o <= oe_n_next;
         we_n_o <= we_n_next;
         data_oe_n_o <= doe_n_next;
         addr_o <= addr_next;
         data_o <= data_next;
         cyc.rdata <= rdata_next;
         cyc.done <= done_next;
         cyc.we_fell <= fell_next;
      end
   end

   a_we_oe_excl: assert property ( // [RULE19]
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !we_n_o |-> oe_n_o && !ce_n_o) else $error("write strobe bad combo");
   a_we_pulse_len: assert property ( // [RULE20]
      @(posedge ref_clk_i) disable iff (!nrst_i)
      $fell(we_n_o) |-> (!we_n_o)[*8]) else $error("write pulse short");
   a_data_at_rise: assert property ( // [RULE8]
      @(posedge ref_clk_i) disable iff (!nrst_i)
      $rose(we_n_o) |-> !data_oe_n_o && $stable(data_o))
      else $error("data lost");
   a_read_no_drive: assert property ( // [RULE5]
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !oe_n_o |-> data_oe_n_o && !ce_n_o) else $error("read contention");
   a_addr_stable: assert property ( // [RULE7]
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !ce_n_o && $past(!ce_n_o) |-> $stable(addr_o))
      else $error("addr moved");
endmodule : pea_strobe
`default_nettype wire

/* File: design/pea_host.sv */
/*
 Host controller for a byte-wide page-mode EEPROM: single reads, byte and
 page writes with the load window kept, then toggle and bit-7 polling.
 Assumes commands are synchronous to ref_clk_i and one device on the pins.
*/
`timescale 1ns/1ps
`default_nettype none
// Rules of the document
// RULE1: Memory is 128K bytes; every access puts 17 address lines out.
// RULE2: No access happens unless chip-select is held low.
// RULE3: A read drives output-drive and chip-select low together.
// RULE4: The device ends a read when either strobe returns high.
// RULE5: Data lines are released whenever output-drive or chip-select is high.
// RULE6: A write has chip-select and write-strobe low, output-drive high.
// RULE7: Address is latched at the later falling strobe; keep it stable.
// RULE8: Data is latched at the first rising strobe; keep it driven.
// RULE9: Programming completes on its own; the host only waits.
// RULE10: Up to 256 byte loads form one page before programming.
// RULE11: Every load of a page keeps address bits 8 to 16 equal.
// RULE12: Next write-strobe fall comes within 100us of the previous one.
// RULE13: Without a new fall within 100us the device starts programming.
// RULE14: While busy, bit 7 of the last byte reads inverted.
// RULE15: After programming, bit 7 of the last byte reads true.
// RULE16: Bit-7 polling fails on a protected device after illegal writes.
// RULE17: While busy, bit 6 flips on every read.
// RULE18: Bit 6 stops flipping when programming ends.
// RULE19: No write with output-drive low, write-strobe or chip-select high.
// RULE20: Write-strobe low pulses under 10ns are ignored.
// RULE21: While busy, only status reads go to the device.
module pea_host #(
   parameter int LOAD_WIN_CYC = pea_pkg::LOAD_WIN_CYC,
   parameter int PROG_MAX_CYC = pea_pkg::PROG_MAX_CYC
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Command port
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic [pea_pkg::ADDR_W-1:0] cmd_addr_i,
   input wire logic [pea_pkg::DATA_W-1:0] cmd_data_i,
   output logic cmd_ready_o,
   // Answers and status
   output logic rd_valid_o,
   output logic [pea_pkg::DATA_W-1:0] rd_data_o,
   output logic busy_o,
   output logic wr_done_o,
   output logic wr_err_o,
   // Memory pins
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic [pea_pkg::ADDR_W-1:0] addr_o,
   output logic [pea_pkg::DATA_W-1:0] data_o,
   output logic data_oe_n_o,
   input wire logic [pea_pkg::DATA_W-1:0] data_i
);
   localparam int TW = pea_pkg::TMR_W;
   localparam int PW = pea_pkg::ADDR_W - pea_pkg::PAGE_LSB;
   localparam logic [TW-1:0] WIN_GO =
      TW'(LOAD_WIN_CYC - pea_pkg::WIN_MARGIN_CYC);
   localparam logic [TW-1:0] CLOSE_AT =
      TW'(LOAD_WIN_CYC + pea_pkg::WIN_MARGIN_CYC);
   localparam logic [TW-1:0] GIVE_UP =
      TW'(LOAD_WIN_CYC + pea_pkg::WIN_MARGIN_CYC + PROG_MAX_CYC);
   localparam logic [8:0] PAGE_FULL = 9'(pea_pkg::PAGE_BYTES);

   typedef enum logic [2:0] {
      M_IDLE = 3'b000, M_BUS = 3'b001, M_OPEN = 3'b010,
      M_CLOSE = 3'b011, M_POLL = 3'b100
   } pea_mst_t;

   // Page field of an address
   function automatic logic [PW-1:0] page_of(
      input logic [pea_pkg::ADDR_W-1:0] a);
      page_of = a[pea_pkg::ADDR_W-1:pea_pkg::PAGE_LSB];
   endfunction : page_of

   pea_cyc_if cyc ();
   pea_mst_t st_reg, st_next;
   logic [TW-1:0] tmr_reg, tmr_next;
   logic [8:0] bytes_reg, bytes_next;
   logic [PW-1:0] page_reg, page_next;
   logic [pea_pkg::ADDR_W-1:0] laddr_reg, laddr_next;
   logic [pea_pkg::DATA_W-1:0] ldata_reg, ldata_next;
   logic pend_reg, pend_next, pwr_reg, pwr_next;
   logic [pea_pkg::ADDR_W-1:0] paddr_reg, paddr_next;
   logic [pea_pkg::DATA_W-1:0] pdata_reg, pdata_next;
   logic prev_reg, prev_next, have_reg, have_next;
   logic start_next, wr_next;
   logic [pea_pkg::ADDR_W-1:0] addr_next;
   logic [pea_pkg::DATA_W-1:0] wdata_next, rd_data_next;
   logic ready_next, rd_valid_next, done_next, err_next, take;

   assign take = cmd_valid_i && cmd_ready_o;

   // Sequencer: launch, page window, close and poll
   always_comb begin
      st_next = st_reg;
      tmr_next = &tmr_reg ? tmr_reg : tmr_reg + TW'(1);
      if (cyc.we_fell) tmr_next = '0; // Window restarts [RULE12]
      bytes_next = bytes_reg;
      page_next = page_reg;
      laddr_next = laddr_reg;
      ldata_next = ldata_reg;
      pend_next = pend_reg;
      pwr_next = pwr_reg;
      paddr_next = paddr_reg;
      pdata_next = pdata_reg;
      prev_next = prev_reg;
      have_next = have_reg;
      start_next = 1'b0;
      wr_next = cyc.wr;
      addr_next = cyc.addr;
      wdata_next = cyc.wdata;
      rd_data_next = rd_data_o;
      rd_valid_next = 1'b0;
      done_next = 1'b0;
      err_next = 1'b0;
      unique case (st_reg)
         M_IDLE: if (pend_reg || take) begin
            st_next = M_BUS;
            start_next = 1'b1;
            pend_next = 1'b0;
            wr_next = pend_reg ? pwr_reg : cmd_write_i;
            addr_next = pend_reg ? paddr_reg : cmd_addr_i;
            wdata_next = pend_reg ? pdata_reg : cmd_data_i;
            if (wr_next) begin
               page_next = page_of(addr_next);
               bytes_next = 9'd1;
               laddr_next = addr_next;
               ldata_next = wdata_next;
            end
         end
         M_BUS: if (cyc.done) begin
            if (!cyc.wr) begin
               rd_valid_next = 1'b1;
               rd_data_next = cyc.rdata;
               st_next = M_IDLE;
            end else if (bytes_reg == PAGE_FULL) begin
               st_next = M_CLOSE; // [RULE10]
            end else begin
               st_next = M_OPEN;
            end
         end
         M_OPEN: if (take && cmd_write_i &&
                     page_of(cmd_addr_i) == page_reg) begin
            st_next = M_BUS; // Same page keeps loading [RULE11]
            start_next = 1'b1;
            wr_next = 1'b1;
            addr_next = cmd_addr_i;
            wdata_next = cmd_data_i;
            bytes_next = bytes_reg + 9'd1;
            laddr_next = cmd_addr_i;
            ldata_next = cmd_data_i;
         end else if (take) begin
            // Other page or a read waits for programming [RULE21]
            st_next = M_CLOSE;
            pend_next = 1'b1;
            pwr_next = cmd_write_i;
            paddr_next = cmd_addr_i;
            pdata_next = cmd_data_i;
         end else if (tmr_reg >= WIN_GO) begin
            st_next = M_CLOSE;
         end
         M_CLOSE: if (tmr_reg >= CLOSE_AT) begin
            // Device has begun programming by now [RULE13] [RULE9]
            st_next = M_POLL;
            start_next = 1'b1;
            wr_next = 1'b0;
            addr_next = laddr_reg;
            have_next = 1'b0;
         end
         M_POLL: if (cyc.done) begin
            // Finished when bit 6 holds and bit 7 is true [RULE17]
            if (have_reg && cyc.rdata[pea_pkg::TOGGLE_BIT] == prev_reg &&
                cyc.rdata[pea_pkg::POLL_BIT] ==
                ldata_reg[pea_pkg::POLL_BIT]) begin
               st_next = M_IDLE; // [RULE15] [RULE18]
               done_next = 1'b1;
            end else if (tmr_reg >= GIVE_UP) begin
               st_next = M_IDLE; // Poll time limit ends the wait [RULE16]
               err_next = 1'b1;
            end else begin
               start_next = 1'b1; // Still busy [RULE14]
               wr_next = 1'b0;
               addr_next = laddr_reg;
               prev_next = cyc.rdata[pea_pkg::TOGGLE_BIT];
               have_next = 1'b1;
            end
         end
         default: st_next = M_IDLE;
      endcase
      ready_next = ((st_next == M_IDLE) && !pend_next) ||
         ((st_next == M_OPEN) && (tmr_next < WIN_GO) && !start_next);
   end

   // Sequencer registers
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= M_IDLE;
         tmr_reg <= '0;
         bytes_reg <= 9'h000;
         page_reg <= '0;
         laddr_reg <= '0;
         ldata_reg <= '0;
         pend_reg <= 1'b0;
         pwr_reg <= 1'b0;
         paddr_reg <= '0;
         pdata_reg <= '0;
         prev_reg <= 1'b0;
         have_reg <= 1'b0;
         cyc.start <= 1'b0;
         cyc.wr <= 1'b0;
         cyc.addr <= '0;
         cyc.wdata <= '0;
         cmd_ready_o <= 1'b0;
         rd_valid_o <= 1'b0;
         rd_data_o <= '0;
         busy_o <= 1'b0;
         wr_done_o <= 1'b0;
         wr_err_o <= 1'b0;
      end else begin
         st_reg <= st_next;
         tmr_reg <= tmr_next;
         bytes_reg <= bytes_next;
         page_reg <= page_next;
         laddr_reg <= laddr_next;
         ldata_reg <= ldata_next;
         pend_reg <= pend_next;
         pwr_reg <= pwr_next;
         paddr_reg <= paddr_next;
         pdata_reg <= pdata_next;
         prev_reg <= prev_next;
         have_reg <= have_next;
         cyc.start <= start_next;
         cyc.wr <= wr_next;
         cyc.addr <= addr_next;
         cyc.wdata <= wdata_next;
         cmd_ready_o <= ready_next;
         rd_valid_o <= rd_valid_next;
         rd_data_o <= rd_data_next;
         busy_o <= (st_next != M_IDLE) || pend_next;
         wr_done_o <= done_next;
         wr_err_o <= err_next;
      end
   end

   // Pin strobe generator
   pea_strobe u_strobe (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .cyc(cyc.cyc),
      .ce_n_o(ce_n_o),
      .oe_n_o(oe_n_o),
      .we_n_o(we_n_o),
      .addr_o(addr_o),
      .data_o(data_o),
      .data_oe_n_o(data_oe_n_o),
      .data_i(data_i)
   );

   a_page_kept: assert property ( // [RULE11]
      @(posedge ref_clk_i) disable iff (!nrst_i)
      st_reg == M_OPEN && start_next |=> page_of(cyc.addr) == page_reg)
      else $error("page changed in load");
   a_load_pace: assert property ( // [RULE12]
      @(posedge ref_clk_i) disable iff (!nrst_i)
      st_reg == M_OPEN && start_next |-> tmr_reg < WIN_GO)
      else $error("byte load too late");
   // Pins stay quiet while the load window runs out
   a_close_wait: assert property ( // [RULE13]
      @(posedge ref_clk_i) disable iff (!nrst_i)
      st_reg == M_CLOSE |-> ce_n_o && we_n_o)
      else $error("pins active while window closes");
   a_busy_no_wr: assert property ( // [RULE21]
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (st_reg == M_POLL || st_reg == M_CLOSE) |-> !(start_next && wr_next))
      else $error("write while programming");
   a_page_limit: assert property ( // [RULE10]
      @(posedge ref_clk_i) disable iff (!nrst_i)
      bytes_reg <= PAGE_FULL) else $error("page overfilled");
endmodule : pea_host
`default_nettype wire

/* File: tb/pea_mem_model.sv */
/*
 Behavioural byte-wide page-mode memory for the host bench.
 Assumes pins are driven off the shared clock; strobes are sampled on its rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pea_mem_model #(
   parameter int LOAD_WIN = 400,
   parameter int PROG_CYC = 300
) (
   // Time base
   input wire logic clk_i,
   // Device pins
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [pea_pkg::ADDR_W-1:0] addr_i,
   input wire logic [pea_pkg::DATA_W-1:0] data_i,
   output logic [pea_pkg::DATA_W-1:0] q_o,
   output logic drive_o,
   // Fault control and observation
   input wire logic stuck_i,
   output logic page_err_o = 1'b0,
   output logic busy_o = 1'b0,
   output int commits_o = 0
);
   logic [7:0] mem [int];
   logic [7:0] pbuf [int];
   logic wr_act;
   logic wr_prev = 1'b0;
   logic rd_prev = 1'b0;
   logic open_q = 1'b0;
   logic tog = 1'b0;
   logic [16:0] lat_a = '0;
   logic [7:0] last_d = '0;
   logic [8:0] page_q = '0;
   int tmr = 0;
   int lowc = 0;
   int pcnt = 0;

   // Write only with select and strobe low, output drive high
   assign wr_act = !ce_n_i && !we_n_i && oe_n_i;
   // Drive only while selected with output drive low
   assign drive_o = !ce_n_i && !oe_n_i;

   // Read value: status while busy, stored byte otherwise
   // No protected state here, so bit-7 polling always runs
   always @(negedge clk_i) begin
      if (busy_o)
         q_o <= {~last_d[7], tog, last_d[5:0]};
      else
         q_o <= mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 8'hff;
   end

   // Strobes, page window and programming
   always @(posedge clk_i) begin
      wr_prev <= wr_act;
      rd_prev <= drive_o;
      tmr <= tmr + 1;
      if (wr_act && !wr_prev) begin
         lat_a <= addr_i;
         lowc <= 1;
         if (!busy_o)
            tmr <= 0;
      end else if (wr_act)
         lowc <= lowc + 1;
      if (!wr_act && wr_prev && lowc >= 3 && !busy_o) begin
         pbuf[int'(lat_a)] = data_i;
         last_d <= data_i;
         if (open_q && lat_a[16:8] != page_q)
            page_err_o <= 1'b1;
         if (!open_q)
            page_q <= lat_a[16:8];
         open_q <= 1'b1;
      end
      if (open_q && tmr >= LOAD_WIN) begin
         open_q <= 1'b0;
         busy_o <= 1'b1;
         pcnt <= 0;
      end
      if (busy_o)
         pcnt <= pcnt + 1;
      if (busy_o && pcnt >= PROG_CYC && !stuck_i) begin
         foreach (pbuf[k])
            mem[k] = pbuf[k];
         pbuf.delete();
         busy_o <= 1'b0;
         commits_o <= commits_o + 1;
      end
      if (drive_o && !rd_prev && busy_o)
         tog <= ~tog;
   end
endmodule : pea_mem_model
`default_nettype wire

/* File: tb/testbench.sv */
/*
 Self-checking bench of the EEPROM host with the memory model.
 Assumes shortened load window and poll limit; seed fixed.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
fails++; $display("unexpected at %0t ns: got %h want %h", $time, \
(got), (exp)); end end
module testbench;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic cv = 1'b0;
   logic cw = 1'b0;
   logic [16:0] ca = '0;
   logic [7:0] cd = '0;
   logic stuck = 1'b0;
   logic rdy, rv, busy, done, err, ce_n, oe_n, we_n, doe_n, mdrv, perr;
   logic [7:0] rd, dout, mq, din, dev_d;
   logic [7:0] flt = 8'h3c;
   logic [16:0] addr, a_fall;
   int commits, fails = 0, check_count = 0, lowc = 0;
   logic [7:0] shadow [int];

   pea_host #(.LOAD_WIN_CYC(400), .PROG_MAX_CYC(2000)) dut_u (
      .ref_clk_i(ref_clk), .nrst_i(nrst), .cmd_valid_i(cv),
      .cmd_write_i(cw), .cmd_addr_i(ca), .cmd_data_i(cd),
      .cmd_ready_o(rdy), .rd_valid_o(rv), .rd_data_o(rd), .busy_o(busy),
      .wr_done_o(done), .wr_err_o(err), .ce_n_o(ce_n), .oe_n_o(oe_n),
      .we_n_o(we_n), .addr_o(addr), .data_o(dout), .data_oe_n_o(doe_n),
      .data_i(din));
   pea_mem_model #(.LOAD_WIN(400), .PROG_CYC(300)) mdl_u (
      .clk_i(ref_clk), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .addr_i(addr), .data_i(dev_d), .q_o(mq), .drive_o(mdrv),
      .stuck_i(stuck), .page_err_o(perr), .busy_o(), .commits_o(commits));

   // Released lines show a changing pattern, not the last value
   always @(posedge ref_clk) flt <= ~flt;
   assign dev_d = doe_n ? flt : dout;
   assign din = mdrv ? mq : dev_d;
   always #2 ref_clk = ~ref_clk;

   // Pin checks on every cycle
   always @(posedge ref_clk) begin
      if (nrst) begin
         `CHK(oe_n | we_n, 1'b1)
         `CHK(oe_n | doe_n, 1'b1)
         `CHK(perr, 1'b0)
         lowc <= we_n ? 0 : lowc + 1;
         if (!we_n && lowc == 0) a_fall <= addr;
         if (we_n && lowc > 0) begin
            `CHK(lowc >= 3, 1'b1)
            `CHK(addr, a_fall)
            `CHK(ce_n, 1'b0)
         end
      end
   end

   function automatic logic [7:0] exp_byte(input logic [16:0] a);
      return shadow.exists(int'(a)) ? shadow[int'(a)] : 8'hff;
   endfunction : exp_byte

   task automatic send(input logic w, input logic [16:0] a,
                       input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      #1;
      cv = 1'b1;
      cw = w;
      ca = a;
      cd = d;
      while (rdy !== 1'b1 && n < 8000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      `CHK(n < 8000, 1'b1)
      @(posedge ref_clk);
      #1;
      cv = 1'b0;
      if (w) shadow[int'(a)] = d;
   endtask : send

   task automatic read_chk(input logic [16:0] a);
      int n;
      n = 0;
      send(1'b0, a, 8'($urandom));
      while (rv !== 1'b1 && n < 8000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      `CHK(rv, 1'b1)
      `CHK(rd, exp_byte(a))
   endtask : read_chk

   task automatic wait_end(output logic [1:0] res);
      int n;
      n = 0;
      while (done !== 1'b1 && err !== 1'b1 && n < 8000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      res = {err, done};
   endtask : wait_end

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   initial begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      $display("unexpected at %0t ns: watchdog expired", $time);
      finish_test();
   end

   initial begin
      logic [1:0] res;
      logic [16:0] a;
      logic [7:0] offs [8];
      int c0;
      void'($urandom(32'heac1));
      repeat (3) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      // Erased location reads all ones
      read_chk({1'b1, 16'($urandom)});
      $display("test erased read done");
      // Single writes, including the top address
      for (int i = 0; i < 3; i++) begin
         a = (i == 0) ? 17'h1_ffff : 17'($urandom);
         send(1'b1, a, 8'($urandom));
         wait_end(res);
         `CHK(res, 2'b01)
         `CHK(mdl_u.busy_o, 1'b0)
         repeat (2) @(posedge ref_clk);
         #1;
         `CHK(busy, 1'b0)
         read_chk(a);
      end
      $display("test single write done");
      // Page load with first and last offsets, one programming cycle
      a = {9'($urandom), 8'h00};
      offs[0] = 8'h00;
      offs[7] = 8'hff;
      for (int i = 1; i < 7; i++) offs[i] = 8'(i * 36 + $urandom % 30);
      c0 = commits;
      foreach (offs[i]) send(1'b1, {a[16:8], offs[i]}, 8'($urandom));
      wait_end(res);
      `CHK(res, 2'b01)
      `CHK(commits - c0, 1)
      foreach (offs[i]) read_chk({a[16:8], offs[i]});
      $display("test page write done");
      // Full page of 256 loads closes without the window timeout
      a = {9'($urandom), 8'h00};
      c0 = commits;
      for (int i = 0; i < 256; i++) send(1'b1, a + 17'(i), 8'($urandom));
      repeat (50) @(posedge ref_clk);
      #1;
      `CHK(rdy, 1'b0)
      wait_end(res);
      `CHK(res, 2'b01)
      `CHK(commits - c0, 1)
      read_chk(a + 17'd255);
      $display("test full page done");
      // Read right behind a write waits for programming
      a = 17'($urandom);
      send(1'b1, a, 8'($urandom));
      // Write to another page while open also waits
      send(1'b1, a ^ 17'h1_0000, 8'($urandom));
      read_chk(a);
      read_chk(a ^ 17'h1_0000);
      $display("test pending read done");
      // Device never finishes: poll gives up
      stuck = 1'b1;
      a = 17'($urandom);
      send(1'b1, a, 8'($urandom));
      wait_end(res);
      `CHK(res, 2'b10)
      stuck = 1'b0;
      repeat (20) @(posedge ref_clk);
      #1;
      read_chk(a);
      $display("test stuck device done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
